/* File: core/ucr_pkg.sv */
// Package for the UART channel register block: map, fields, types
package ucr_pkg;
  // Register offsets on the three address lines
  localparam logic [2:0] ADR_DATA = 3'h0;
  localparam logic [2:0] ADR_IER  = 3'h1;
  localparam logic [2:0] ADR_ISR  = 3'h2;
  localparam logic [2:0] ADR_LCR  = 3'h3;
  localparam logic [2:0] ADR_MCR  = 3'h4;
  localparam logic [2:0] ADR_LSR  = 3'h5;
  localparam logic [2:0] ADR_MSR  = 3'h6;
  localparam logic [2:0] ADR_SPR  = 3'h7;
  // Line control fields
  localparam int LCR_STOP  = 2;
  localparam int LCR_PEN   = 3;
  localparam int LCR_EVEN  = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_BRK   = 6;
  localparam int LCR_DLAB  = 7;
  // Modem and FIFO control fields
  localparam int MCR_LOOP  = 4;
  localparam int FCR_EN    = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_DMA   = 3;
  // Interrupt source codes
  localparam logic [3:0] ISR_LSR  = 4'h6;
  localparam logic [3:0] ISR_RXR  = 4'h4;
  localparam logic [3:0] ISR_THRE = 4'h2;
  localparam logic [3:0] ISR_MSR  = 4'h0;
  localparam logic [3:0] ISR_NONE = 4'h1;
  // Buffer shapes
  localparam int RXF_W     = 11;
  localparam int RXF_DEPTH = 16;
  localparam int TXF_W     = 8;
  localparam int TXF_DEPTH = 32;
  // Sample points in 16x ticks, reset values
  localparam logic [3:0]  SMP_MID  = 4'h7;
  localparam logic [3:0]  SMP_END  = 4'hf;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  localparam logic [4:0]  SYNC_RST = 5'h1f;
  localparam logic [3:0]  MCTL_RST = 4'hf;

  typedef enum logic [2:0] {UCR_IDLE, UCR_START, UCR_DATA, UCR_PAR, UCR_STOP} ucr_phase_e;

  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ucr_bus_s;

  typedef struct packed {
    logic cd_b;
    logic ri_b;
    logic dsr_b;
    logic cts_b;
  } ucr_modem_s;

  typedef struct packed {
    logic op2_b;
    logic op1_b;
    logic rts_b;
    logic dtr_b;
  } ucr_mctl_s;

  typedef struct packed {
    logic [3:0]  irq_enable;
    logic [7:0]  line_control;
    logic [4:0]  modem_control;
    logic [7:0]  scratch_pad;
    logic [15:0] div;
    logic        fifo_en;
    logic        dma;
    logic [1:0]  trig;
    logic [7:0]  rdata;
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [3:0]  mst;
    logic [3:0]  mdelta;
    logic        ovr;
    logic        thre;
    logic        txe_p;
    logic [4:0]  errcnt;
    logic [15:0] bcnt;
    ucr_phase_e  tph;
    logic [3:0]  tcnt;
    logic [2:0]  tn;
    logic [7:0]  tsh;
    logic        tpar;
    logic        tline;
    ucr_phase_e  rph;
    logic [3:0]  rcnt;
    logic [2:0]  rn;
    logic [7:0]  rsh;
    logic        rzero;
    logic        rarm;
    logic        rpe;
    logic        txo;
    ucr_mctl_s   mctl;
    logic        space;
  } ucr_state_s;
endpackage

/* File: core/ucr_channel.sv */
// UART channel: register set, receive tag FIFO, transmit buffer, loopback
// Summary of operation
// - Host reads received byte from holding register
// - Receive FIFO: sixteen entries, byte plus tags
// - FIFO mode shows oldest queued character
// - Read advances queue; status tags follow head
// - Modem control bit four enables loopback
// - Loopback routes transmit shifter into receiver
// - Loopback: mark on line, outputs off
// - Everything else keeps working during loopback; modem states follow control bits, not pins
// - Three address lines select eight registers
// - Offset zero: receive read, transmit write
// - Offset one: interrupt enables, upper zero
// - Offset two read: FIFO flags, source
// - Offset two write: FIFO control fields
// - Offset three: line format and banking
// - Offset four: modem outputs, loopback
// - Offset five: receive and transmit status
// - Offset six: modem deltas and states
// - Offset seven: scratch byte, no effect
// - Banked offsets hold sixteen-bit divisor
// - Global error while any tagged entry
`timescale 1ns/1ps
`default_nettype none

module ucr_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         clr_i,
  // Fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Drain side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } ucr_fifo_s;

  ucr_fifo_s q, d;
  logic      push;
  logic      pop;

  assign in_ready_o  = q.cnt != (AW+1)'(D);
  assign out_valid_o = q.cnt != '0;
  assign out_data_o  = q.mem[q.rp];

  always_comb begin
    d = q;
    push = in_valid_i & in_ready_o;
    pop = out_valid_o & out_ready_i;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Pointer reset only; stored words are left stale
    if (clr_i) begin
      d.wp = '0;
      d.rp = '0;
      d.cnt = '0;
    end
    if (!rst_b_i) begin
      d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end
endmodule

module ucr_channel (
  // Clock and reset
  input  wire logic                REF_CLK_I,
  input  wire logic                RST_B_I,
  // Host register bus
  input  wire ucr_pkg::ucr_bus_s   HOST_I,
  output logic [7:0]               RDATA_O,
  output logic                     TX_SPACE_O,
  // Serial line and modem pins
  input  wire logic                RX_I,
  input  wire ucr_pkg::ucr_modem_s MODEM_B_I,
  output logic                     TX_O,
  output ucr_pkg::ucr_mctl_s       MCTL_B_O
);
  import ucr_pkg::*;

  ucr_state_s         q, d;
  logic               rd_hit;
  logic               wr_hit;
  logic               dlab;
  logic               loop;
  logic               tick;
  logic               rxl;
  logic [3:0]         mnow;
  logic [2:0]         last;
  logic               rx_pop;
  logic               rx_push;
  logic               rx_ok;
  logic [2:0]         rx_tag;
  logic               rx_clr;
  logic               tx_clr;
  logic               tx_push;
  logic               tx_ok;
  logic               tx_pop;
  logic               txe;
  logic [3:0]         irq_status;
  logic [7:0]         line_status;
  logic [7:0]         rv;
  logic               rxf_rdy;
  logic               rxf_vld;
  logic [RXF_W-1:0]   rxf_data;
  logic               txf_rdy;
  logic               txf_vld;
  logic [TXF_W-1:0]   txf_data;

  // Expected parity bit for the live word length and mode
  function automatic logic par_bit(input logic [7:0] data, input logic [7:0] line_control);
    logic [7:0] m;
    m = data & (8'hff >> (2'h3 - line_control[1:0]));
    if (line_control[LCR_STICK]) begin
      par_bit = ~line_control[LCR_EVEN];
    end else begin
      par_bit = (^m) ^ ~line_control[LCR_EVEN];
    end
  endfunction

  // Three error tags travel with every received byte
  ucr_fifo #(.W(RXF_W), .D(RXF_DEPTH)) u_rxf (
    .clk_i       (REF_CLK_I),
    .rst_b_i     (RST_B_I),
    .clr_i       (rx_clr),
    .in_valid_i  (rx_push & rx_ok),
    .in_data_i   ({rx_tag, q.rsh}),
    .in_ready_o  (rxf_rdy),
    .out_valid_o (rxf_vld),
    .out_data_o  (rxf_data),
    .out_ready_i (rx_pop)
  );

  // Transmitter drains this; a busy shifter stalls it
  ucr_fifo #(.W(TXF_W), .D(TXF_DEPTH)) u_txf (
    .clk_i       (REF_CLK_I),
    .rst_b_i     (RST_B_I),
    .clr_i       (tx_clr),
    .in_valid_i  (tx_push & tx_ok),
    .in_data_i   (HOST_I.wdata),
    .in_ready_o  (txf_rdy),
    .out_valid_o (txf_vld),
    .out_data_o  (txf_data),
    .out_ready_i (tx_pop)
  );

  assign RDATA_O    = q.rdata;
  assign TX_O       = q.txo;
  assign MCTL_B_O   = q.mctl;
  assign TX_SPACE_O = q.space;

  // Bus is same-clock logic; one-cycle strobes
  assign rd_hit = HOST_I.cs & HOST_I.rd;
  assign wr_hit = HOST_I.cs & HOST_I.wr;
  assign dlab   = q.line_control[LCR_DLAB];
  assign loop   = q.modem_control[MCR_LOOP];
  assign tick   = q.bcnt >= (q.div - 16'h0001);
  assign last   = 3'h4 + {1'b0, q.line_control[1:0]};
  assign txe    = ~txf_vld;
  // Non-FIFO mode keeps a single byte on each side
  assign rx_ok  = q.fifo_en ? rxf_rdy : ~rxf_vld;
  assign tx_ok  = q.fifo_en ? txf_rdy : ~txf_vld;

  // Break on the shifter output is seen by the receiver too
  assign rxl = loop ? (~q.line_control[LCR_BRK] & q.tline) : q.s2[4];
  // Active-high modem states {cd, ri, dsr, cts}
  assign mnow = loop ? {q.modem_control[3], q.modem_control[2], q.modem_control[0], q.modem_control[1]} : ~q.s2[3:0];

  always_comb begin
    if (q.irq_enable[2] && (q.ovr || (rxf_vld && (|rxf_data[10:8])))) begin
      irq_status = ISR_LSR;
    end else if (q.irq_enable[0] && rxf_vld) begin
      irq_status = ISR_RXR;
    end else if (q.irq_enable[1] && q.thre) begin
      irq_status = ISR_THRE;
    end else if (q.irq_enable[3] && (|q.mdelta)) begin
      irq_status = ISR_MSR;
    end else begin
      irq_status = ISR_NONE;
    end
  end

  // Tags shown are those of the byte now at the head
  assign line_status = {q.errcnt != 5'h00, txe & (q.tph == UCR_IDLE), txe,
                rxf_vld ? rxf_data[10:8] : 3'h0, q.ovr, rxf_vld};

  always_comb begin
    case (HOST_I.addr)
      ADR_DATA: rv = dlab ? q.div[7:0] : rxf_data[7:0];
      ADR_IER:  rv = dlab ? q.div[15:8] : {4'h0, q.irq_enable};
      ADR_ISR:  rv = {{2{q.fifo_en}}, 2'h0, irq_status};
      ADR_LCR:  rv = q.line_control;
      ADR_MCR:  rv = {3'h0, q.modem_control};
      ADR_LSR:  rv = line_status;
      ADR_MSR:  rv = {q.mst, q.mdelta};
      ADR_SPR:  rv = q.scratch_pad;
      default:  rv = 8'h00;
    endcase
  end

  always_comb begin
    d = q;
    rx_pop = 1'b0;
    rx_push = 1'b0;
    rx_tag = 3'h0;
    rx_clr = 1'b0;
    tx_clr = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    d.s1 = {RX_I, MODEM_B_I};
    d.s2 = q.s1;
    d.bcnt = tick ? 16'h0000 : q.bcnt + 16'h0001;

    // Register writes
    if (wr_hit) begin
      case (HOST_I.addr)
        ADR_DATA: begin
          if (dlab) begin
            d.div[7:0] = HOST_I.wdata;
          end else begin
            tx_push = 1'b1;
          end
        end
        ADR_IER: begin
          if (dlab) begin
            d.div[15:8] = HOST_I.wdata;
          end else begin
            d.irq_enable = HOST_I.wdata[3:0];
          end
        end
        ADR_ISR: begin
          // Other fields only take effect with the enable set
          d.fifo_en = HOST_I.wdata[FCR_EN];
          if (HOST_I.wdata[FCR_EN]) begin
            d.dma = HOST_I.wdata[FCR_DMA];
            d.trig = HOST_I.wdata[7:6];
            rx_clr = HOST_I.wdata[FCR_RXRST];
            tx_clr = HOST_I.wdata[FCR_TXRST];
          end
        end
        ADR_LCR: d.line_control = HOST_I.wdata;
        ADR_MCR: d.modem_control = HOST_I.wdata[4:0];
        ADR_SPR: d.scratch_pad = HOST_I.wdata;
        default: ;
      endcase
    end

    // Register reads and their side effects
    if (rd_hit) begin
      d.rdata = rv;
      if (HOST_I.addr == ADR_DATA && !dlab) begin
        rx_pop = rxf_vld;
      end
    end

    // Modem deltas: a new change beats the read clear
    d.mst = mnow;
    d.mdelta = (q.mdelta & ~{4{rd_hit && HOST_I.addr == ADR_MSR}}) | (mnow ^ q.mst);

    // Transmit shifter
    case (q.tph)
      UCR_IDLE: begin
        d.tline = 1'b1;
        if (txf_vld) begin
          tx_pop = 1'b1;
          d.tsh = txf_data;
          d.tpar = par_bit(txf_data, q.line_control);
          d.tph = UCR_START;
          d.tline = 1'b0;
          d.tcnt = 4'h0;
        end
      end
      default: begin
        if (tick) begin
          d.tcnt = q.tcnt + 4'h1;
          if (q.tcnt == SMP_END) begin
            case (q.tph)
              UCR_START: begin
                d.tph = UCR_DATA;
                d.tn = 3'h0;
                d.tline = q.tsh[0];
              end
              UCR_DATA: begin
                if (q.tn == last) begin
                  d.tph = q.line_control[LCR_PEN] ? UCR_PAR : UCR_STOP;
                  d.tline = q.line_control[LCR_PEN] ? q.tpar : 1'b1;
                  d.tn = 3'h0;
                end else begin
                  d.tn = q.tn + 3'h1;
                  d.tline = q.tsh[d.tn];
                end
              end
              UCR_PAR: begin
                d.tph = UCR_STOP;
                d.tline = 1'b1;
                d.tn = 3'h0;
              end
              default: begin
                // Second stop bit when selected
                if (q.line_control[LCR_STOP] && q.tn == 3'h0) begin
                  d.tn = 3'h1;
                end else begin
                  d.tph = UCR_IDLE;
                end
              end
            endcase
          end
        end
      end
    endcase

    // Receive shifter; rearms only after the line returns high
    case (q.rph)
      UCR_IDLE: begin
        if (rxl) begin
          d.rarm = 1'b1;
        end
        if (tick && q.rarm && !rxl) begin
          d.rph = UCR_START;
          d.rcnt = 4'h0;
          d.rarm = 1'b0;
        end
      end
      UCR_START: begin
        if (tick) begin
          d.rcnt = q.rcnt + 4'h1;
          if (q.rcnt == SMP_MID) begin
            // A start bit gone high again was noise
            d.rph = rxl ? UCR_IDLE : UCR_DATA;
            d.rarm = rxl;
            d.rcnt = 4'h0;
            d.rn = 3'h0;
            d.rsh = 8'h00;
            d.rzero = 1'b1;
            d.rpe = 1'b0;
          end
        end
      end
      default: begin
        if (tick) begin
          d.rcnt = q.rcnt + 4'h1;
          if (q.rcnt == SMP_END) begin
            d.rzero = q.rzero & ~rxl;
            case (q.rph)
              UCR_DATA: begin
                d.rsh[q.rn] = rxl;
                if (q.rn == last) begin
                  d.rph = q.line_control[LCR_PEN] ? UCR_PAR : UCR_STOP;
                end else begin
                  d.rn = q.rn + 3'h1;
                end
              end
              UCR_PAR: begin
                d.rpe = rxl != par_bit(q.rsh, q.line_control);
                d.rph = UCR_STOP;
              end
              default: begin
                rx_push = 1'b1;
                rx_tag = {q.rzero & ~rxl, ~rxl, q.rpe};
                d.rph = UCR_IDLE;
              end
            endcase
          end
        end
      end
    endcase

    // Tagged-entry count behind the global error flag
    d.errcnt = q.errcnt + 5'(rx_push & rx_ok & rxf_rdy & (|rx_tag))
             - 5'(rx_pop & (|rxf_data[10:8]));
    if (rx_clr) begin
      d.errcnt = 5'h00;
    end

    // Overrun: a lost byte beats the status read clear
    d.ovr = (rx_push & ~rx_ok) | (q.ovr & ~(rd_hit && HOST_I.addr == ADR_LSR));

    // Transmit-empty event, cleared by an offset two read that shows it as source, or new data
    d.txe_p = txe;
    d.thre = (txe & (~q.txe_p | (q.irq_enable[1] ^ d.irq_enable[1]) & d.irq_enable[1]))
           | (q.thre & ~((rd_hit && HOST_I.addr == ADR_ISR && irq_status == ISR_THRE) | tx_push));

    // Pins, registered; loopback marks the line and idles outputs
    d.txo = loop | (~q.line_control[LCR_BRK] & q.tline);
    d.mctl = loop ? MCTL_RST : ~{q.modem_control[3], q.modem_control[2], q.modem_control[1], q.modem_control[0]};
    d.space = tx_ok;

    if (!RST_B_I) begin
      d = '0;
      d.div = DIV_RST;
      d.s1 = SYNC_RST;
      d.s2 = SYNC_RST;
      d.tline = 1'b1;
      d.txo = 1'b1;
      d.mctl = MCTL_RST;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    q <= d;
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_spr_wr;
    wr_hit && HOST_I.addr == ADR_SPR;
  endsequence
  sequence s_spr_rd;
    rd_hit && !wr_hit && HOST_I.addr == ADR_SPR;
  endsequence

  a_spr_echo: assert property (s_spr_wr ##1 s_spr_rd |=> RDATA_O == $past(HOST_I.wdata, 2))
    else $error("scratch read differs from last write");
  a_loop_mark: assert property (loop ##1 loop |-> TX_O && MCTL_B_O.rts_b && MCTL_B_O.dtr_b)
    else $error("loopback pins not idle");
  a_ier_upper: assert property (rd_hit && HOST_I.addr == ADR_IER && !dlab |=> RDATA_O[7:4] == 4'h0)
    else $error("enable register upper bits set");
  a_isr_fifo: assert property (rd_hit && HOST_I.addr == ADR_ISR
                               |=> RDATA_O[7:4] == {{2{$past(q.fifo_en)}}, 2'h0})
    else $error("status upper bits wrong");
  a_mcr_upper: assert property (rd_hit && HOST_I.addr == ADR_MCR |=> RDATA_O[7:5] == 3'h0)
    else $error("modem control upper bits set");
  a_rhr_head: assert property (rd_hit && HOST_I.addr == ADR_DATA && !dlab && rxf_vld
                               |=> RDATA_O == $past(rxf_data[7:0]))
    else $error("holding read not oldest byte");
  a_lsr_tags: assert property (rd_hit && HOST_I.addr == ADR_LSR
                               |=> RDATA_O[4:0] == $past({rxf_vld ? rxf_data[10:8] : 3'h0, q.ovr, rxf_vld}))
    else $error("line status tags wrong");
  a_lsr_gerr: assert property (rd_hit && HOST_I.addr == ADR_LSR
                               |=> RDATA_O[7] == ($past(q.errcnt) != 5'h00))
    else $error("global error flag wrong");
  a_div_bank: assert property (wr_hit && dlab && HOST_I.addr == ADR_DATA
                               |=> q.div[7:0] == $past(HOST_I.wdata) && $stable(q.irq_enable))
    else $error("divisor low byte not written");
  a_loop_msr: assert property (rd_hit && HOST_I.addr == ADR_MSR && loop && $past(loop) && $stable(q.modem_control)
                               |=> RDATA_O[7:4] == $past({q.modem_control[3], q.modem_control[2], q.modem_control[0], q.modem_control[1]}))
    else $error("loopback modem states wrong");
endmodule

`default_nettype wire

/* File: dv/ucr_line_model.sv */
// Far-side serial line and modem pin model for the channel bench
`timescale 1ns/1ps
`default_nettype none

module ucr_line_model (
  // Modem lines to assert, high = asserted
  input  wire logic         asrt_i,
  input  wire logic [3:0]   lines_i,
  // Pins toward the channel
  output logic              rx_o,
  output ucr_pkg::ucr_modem_s modem_b_o
);
  import ucr_pkg::*;
  // Receive line stays at mark so loopback exit sees no false break
  assign rx_o = 1'b1;
  // Pins are active low
  assign modem_b_o = asrt_i ? ~lines_i : 4'hf;
endmodule

`default_nettype wire

/* File: dv/ucr_channel_tb_top.sv */
// Register-level bench for the UART channel block
`timescale 1ns/1ps
`default_nettype none

module ucr_channel_tb_top;
  import ucr_pkg::*;
  logic       ref_clk    = 1'b0;
  logic       rst_b      = 1'b0;
  ucr_bus_s   host       = '0;
  logic       asrt       = 1'b0;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic [7:0] tbyte      = 8'h4b;
  logic       tx;
  logic       rx;
  logic       space;
  ucr_modem_s modem_b;
  ucr_mctl_s  mctl_b;
  int         n_mismatch = 0;
  int         cmp_count  = 0;
  int         k;

  always #25 ref_clk = ~ref_clk;

  ucr_channel ucr_channel_inst (
    .REF_CLK_I  (ref_clk),
    .RST_B_I    (rst_b),
    .HOST_I     (host),
    .RDATA_O    (rdata),
    .TX_SPACE_O (space),
    .RX_I       (rx),
    .MODEM_B_I  (modem_b),
    .TX_O       (tx),
    .MCTL_B_O   (mctl_b)
  );

  ucr_line_model ucr_line_model_inst (
    .asrt_i    (asrt),
    .lines_i   (4'hf),
    .rx_o      (rx),
    .modem_b_o (modem_b)
  );

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timed_out(input string what);
    n_mismatch++;
    $display("wrong value %s expected done seen timeout", what);
    finish_test();
  endtask

  // One strobe cycle, then an idle cycle before the next access
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    host <= '{cs: 1'b1, rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge ref_clk);
    host <= '0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    host <= '{cs: 1'b1, rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    host <= '0;
    v = rdata;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    rd(a, v);
    chk(what, v, exp);
  endtask

  // Status polls double as the bounded wait
  task automatic wait_lsr(input logic [7:0] m);
    for (k = 0; k < 3000; k++) begin
      rd(ADR_LSR, rv);
      if ((rv & m) === m) break;
    end
    if (k == 3000) timed_out("line_status poll");
  endtask

  initial begin
    repeat (8) @(negedge ref_clk);
    rst_b <= 1'b1;
    chk("modem pins reset", {4'h0, mctl_b}, 8'h0f);
    rchk(ADR_IER, 8'h00, "irq_enable reset");
    rchk(ADR_LCR, 8'h00, "line_control reset");
    rchk(ADR_MCR, 8'h00, "modem_control reset");
    rchk(ADR_SPR, 8'h00, "scratch_pad reset");
    rchk(ADR_ISR, 8'h01, "irq_status reset");
    chk("tx space reset", {7'h0, space}, 8'h01);
    $display("test reset values done");

    wr(ADR_SPR, 8'ha5);
    rchk(ADR_SPR, 8'ha5, "scratch_pad");
    wr(ADR_IER, 8'hff);
    rchk(ADR_IER, 8'h0f, "irq_enable upper");
    wr(ADR_IER, 8'h05);
    wr(ADR_LCR, 8'h9b);
    rchk(ADR_LCR, 8'h9b, "line_control");
    wr(ADR_DATA, 8'h34);
    wr(ADR_IER, 8'h12);
    rchk(ADR_DATA, 8'h34, "divisor_low");
    rchk(ADR_IER, 8'h12, "divisor_high");
    wr(ADR_DATA, 8'h01);
    wr(ADR_IER, 8'h00);
    wr(ADR_LCR, 8'h03);
    rchk(ADR_IER, 8'h05, "irq_enable banked");
    wr(ADR_IER, 8'h00);
    wr(ADR_MCR, 8'hff);
    rchk(ADR_MCR, 8'h1f, "modem_control upper");
    chk("modem pins loop", {4'h0, mctl_b}, 8'h0f);
    rchk(ADR_MSR, 8'hff, "modem_status loop");
    rchk(ADR_MSR, 8'hf0, "modem_status cleared");
    asrt = 1'b1;
    wr(ADR_MCR, 8'h1a);
    repeat (4) @(negedge ref_clk);
    rchk(ADR_MSR, 8'h96, "modem_status pins ignored");
    $display("test registers done");

    wr(ADR_ISR, 8'h07);
    rchk(ADR_ISR, 8'hc1, "irq_status fifo on");
    wr(ADR_MCR, 8'h10);
    // One byte past the receive depth to force an overrun
    for (int i = 0; i < 17; i++) begin
      wr(ADR_DATA, 8'h40 + 8'(i));
    end
    chk("tx pin loop", {7'h0, tx}, 8'h01);
    chk("modem pins loop", {4'h0, mctl_b}, 8'h0f);
    // Fixed wait: polling the status would clear the overrun flag
    repeat (3000) @(negedge ref_clk);
    rchk(ADR_LSR, 8'h63, "line_status full");
    for (int i = 0; i < 16; i++) begin
      rchk(ADR_DATA, 8'h40 + 8'(i), "rx_holding order");
    end
    rchk(ADR_LSR, 8'h60, "line_status drained");
    $display("test loopback fifo done");

    // Break bit forces the looped line low for more than one frame
    wr(ADR_LCR, 8'h43);
    repeat (200) @(negedge ref_clk);
    chk("tx pin break", {7'h0, tx}, 8'h01);
    wr(ADR_LCR, 8'h03);
    repeat (20) @(negedge ref_clk);
    rd(ADR_LSR, rv);
    chk("line_status break", rv & 8'h91, 8'h91);
    rchk(ADR_DATA, 8'h00, "rx_holding break");
    rd(ADR_LSR, rv);
    chk("line_status clear", rv & 8'h81, 8'h00);
    $display("test break tags done");

    wr(ADR_MCR, 8'h03);
    // Pins follow the register one edge later
    @(negedge ref_clk);
    chk("modem pins normal", {4'h0, mctl_b}, 8'h0c);
    repeat (4) @(negedge ref_clk);
    rd(ADR_MSR, rv);
    rchk(ADR_MSR, 8'hf0, "modem_status pins");
    wr(ADR_DATA, tbyte);
    for (k = 0; k < 100; k++) begin
      @(negedge ref_clk);
      if (tx === 1'b0) break;
    end
    if (k == 100) timed_out("start bit");
    repeat (8) @(negedge ref_clk);
    chk("start bit", {7'h0, tx}, 8'h00);
    for (int b = 0; b < 8; b++) begin
      repeat (16) @(negedge ref_clk);
      chk("data bit", {7'h0, tx}, {7'h0, tbyte[b]});
    end
    repeat (16) @(negedge ref_clk);
    chk("stop bit", {7'h0, tx}, 8'h01);
    $display("test serial transmit done");
    finish_test();
  end
endmodule

`default_nettype wire
